// *** hdl/ssc_defines.vh ***
// Register map, field positions, reset values and timing of the status and control bank
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH

// Register offsets
`define SSC_OFS_IDENT        8'h00
`define SSC_OFS_STATE        8'h01
`define SSC_OFS_MODE         8'h02
`define SSC_OFS_MON_LGAIN    8'h0f
`define SSC_OFS_MON_RGAIN    8'h10
`define SSC_OFS_PT_CTRL_A    8'h11
`define SSC_OFS_PT_CTRL_B    8'h12
`define SSC_OFS_PT_LGAIN     8'h13
`define SSC_OFS_PT_RGAIN     8'h14
`define SSC_OFS_GL_CTRL      8'h15
`define SSC_OFS_GL_TIMING    8'h16
`define SSC_OFS_GL_HOLD      8'h17
`define SSC_OFS_GL_START     8'h18
`define SSC_OFS_MT_CTRL      8'h1a
`define SSC_OFS_NVM_CTRL     8'h34

// System state flag positions
`define SSC_BIT_TEST_PASS    4
`define SSC_BIT_NVM_IDLE     3
`define SSC_BIT_STARTUP_DONE 1
`define SSC_BIT_KEEP_ALIVE   0

// Mode register: bus-control mode bit
`define SSC_BIT_BUS_MODE     0

// Mode transition control: grace time field
`define SSC_GRACE_HI         5
`define SSC_GRACE_LO         4

// Transfer control: command bits
`define SSC_BIT_NVM_TEST     2

// Reset values
`define SSC_RST_KEEP_ALIVE   1'b1
`define SSC_RST_MODE         8'h4c
`define SSC_RST_CFG          8'h00

// Writable bit masks
`define SSC_MSK_GAIN         8'h7f
`define SSC_MSK_PT_CTRL_A    8'hb3
`define SSC_MSK_FULL         8'hff
`define SSC_MSK_GL_START     8'h07
`define SSC_MSK_MT_CTRL      8'h3f
`define SSC_MSK_NVM_CTRL     8'h07

// Timing: clock period and grace time step
`define SSC_CLK_PERIOD_NS    10
`define SSC_GRACE_UNIT_NS    1000000

// Default bus address of the device
`define SSC_DEV_ADDR         7'h40

`endif

// *** hdl/ssc_i2c_slave.v ***
// Oversampled I2C slave with register pointer and auto-increment
`include "ssc_defines.vh"

module ssc_i2c_slave #(
    parameter [6:0] DEV_ADDR = `SSC_DEV_ADDR
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       nrst,
    // Bus pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output reg        sda_oe,
    // Register side
    input  wire [7:0] rd_data,
    output reg  [7:0] reg_ptr,
    output reg        wr_pulse,
    output reg  [7:0] wr_addr,
    output reg  [7:0] wr_data,
    output reg        start_pulse
);
    localparam [5:0] S_IDLE = 6'b000001;
    localparam [5:0] S_ADDR = 6'b000010;
    localparam [5:0] S_ACK  = 6'b000100;
    localparam [5:0] S_WR   = 6'b001000;
    localparam [5:0] S_RD   = 6'b010000;
    localparam [5:0] S_RACK = 6'b100000;

    reg [2:0] scl_sync;
    reg [2:0] sda_sync;
    reg       scl_f;
    reg       sda_f;
    reg [5:0] state;
    reg [3:0] cnt;
    reg [7:0] shreg;
    reg [7:0] tx;
    reg       is_read;
    reg       ptr_phase;

    // Pin levels count only once the second and third stages agree
    wire scl_ok  = (scl_sync[1] == scl_sync[2]);
    wire sda_ok  = (sda_sync[1] == sda_sync[2]);
    wire scl_new = scl_ok ? scl_sync[2] : scl_f;
    wire sda_new = sda_ok ? sda_sync[2] : sda_f;
    wire scl_rise = scl_new & ~scl_f;
    wire scl_fall = ~scl_new & scl_f;
    wire is_start = scl_f & scl_new & sda_f & ~sda_new;
    wire is_stop  = scl_f & scl_new & ~sda_f & sda_new;

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            scl_sync <= 3'b111;
            sda_sync <= 3'b111;
            scl_f    <= 1'b1;
            sda_f    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            scl_f    <= scl_new;
            sda_f    <= sda_new;
        end
    end

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state       <= S_IDLE;
            cnt         <= 4'h0;
            shreg       <= 8'h00;
            tx          <= 8'h00;
            is_read     <= 1'b0;
            ptr_phase   <= 1'b0;
            sda_oe      <= 1'b0;
            reg_ptr     <= 8'h00;
            wr_pulse    <= 1'b0;
            wr_addr     <= 8'h00;
            wr_data     <= 8'h00;
            start_pulse <= 1'b0;
        end else begin
            wr_pulse    <= 1'b0;
            start_pulse <= 1'b0;
            if (is_start) begin
                state       <= S_ADDR;
                cnt         <= 4'h0;
                sda_oe      <= 1'b0;
                start_pulse <= 1'b1;
            end else if (is_stop) begin
                state  <= S_IDLE;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                if (state == S_ADDR || state == S_WR || state == S_RD) begin
                    shreg <= {shreg[6:0], sda_new};
                    cnt   <= cnt + 4'h1;
                end
                if (state == S_RACK) begin
                    is_read <= ~sda_new;
                end
            end else if (scl_fall) begin
                case (state)
                    S_ADDR: begin
                        if (cnt == 4'h8) begin
                            if (shreg[7:1] == DEV_ADDR) begin
                                sda_oe    <= 1'b1;
                                is_read   <= shreg[0];
                                ptr_phase <= ~shreg[0];
                                state     <= S_ACK;
                            end else begin
                                state <= S_IDLE;
                            end
                        end
                    end
                    S_WR: begin
                        if (cnt == 4'h8) begin
                            sda_oe <= 1'b1;
                            state  <= S_ACK;
                            if (ptr_phase) begin
                                reg_ptr   <= shreg;
                                ptr_phase <= 1'b0;
                            end else begin
                                wr_pulse <= 1'b1;
                                wr_addr  <= reg_ptr;
                                wr_data  <= shreg;
                                reg_ptr  <= reg_ptr + 8'h01;
                            end
                        end
                    end
                    S_ACK: begin
                        cnt <= 4'h0;
                        if (is_read) begin
                            tx     <= rd_data;
                            sda_oe <= ~rd_data[7];
                            state  <= S_RD;
                        end else begin
                            sda_oe <= 1'b0;
                            state  <= S_WR;
                        end
                    end
                    S_RD: begin
                        if (cnt == 4'h8) begin
                            sda_oe  <= 1'b0;
                            reg_ptr <= reg_ptr + 8'h01;
                            state   <= S_RACK;
                        end else begin
                            tx     <= {tx[6:0], 1'b0};
                            sda_oe <= ~tx[6];
                        end
                    end
                    S_RACK: begin
                        cnt <= 4'h0;
                        if (is_read) begin
                            tx     <= rd_data;
                            sda_oe <= ~rd_data[7];
                            state  <= S_RD;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                    default: begin
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

// *** hdl/ssc_regs.v ***
// System status, power keep-alive and control register bank behind the I2C slave
//
// Function
// - Identification reads revision code high nibble, part code low; writes ignored.
// - State bit 4 reports nonvolatile upload test result, read-only.
// - Writing the test command bit starts a dummy program write; result reported.
// - State bit 3 shows nonvolatile memory idle, 0 while busy.
// - State bit 1 shows startup sequencer done; passes startup_done_flag through, no reset value.
// - State bit 0 keeps power; host writing 0 powers down.
// - After such power-down, an I2C start condition wakes the device.
// - Keep-alive acts only with bus-control mode set; otherwise never powers down.
// - All registers stay accessible over I2C whatever the bus-control mode.
`include "ssc_defines.vh"

module ssc_regs #(
    parameter [6:0]  DEV_ADDR          = `SSC_DEV_ADDR,
    parameter [3:0]  REVISION_CODE     = 4'h3,
    parameter [3:0]  PART_CODE         = 4'h5,
    parameter [31:0] GRACE_UNIT_CYCLES = `SSC_GRACE_UNIT_NS / `SSC_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire       mclk,
    input  wire       nrst,
    // I2C pins
    input  wire       scl_in,
    input  wire       sda_in,
    output wire       sda_out,
    output wire       sda_oe,
    // Status from nonvolatile memory engine and sequencer
    input  wire       nvm_idle_flag,
    input  wire       nvm_test_pass_flag,
    input  wire       startup_done_flag,
    // Power control
    output wire       device_powered,
    output wire       bus_mode,
    // Nonvolatile memory commands, one-cycle pulses
    output reg  [2:0] nvm_cmd_pulse,
    // Control register contents
    output wire [7:0] mode_ctrl,
    output wire [7:0] monitor_left_mic_gain,
    output wire [7:0] monitor_right_mic_gain,
    output wire [7:0] passthrough_mode_ctrl_a,
    output wire [7:0] passthrough_mode_ctrl_b,
    output wire [7:0] passthrough_left_mic_gain,
    output wire [7:0] passthrough_right_mic_gain,
    output wire [7:0] gain_loop_ctrl,
    output wire [7:0] gain_loop_timing,
    output wire [7:0] gain_loop_hold_timeout,
    output wire [7:0] gain_loop_startup,
    output wire [7:0] mode_transition_ctrl,
    output wire [7:0] nvm_transfer_ctrl
);
    localparam       NCFG   = 13;
    localparam [3:0] NOSLOT = 4'hf;
    localparam [2:0] P_ON   = 3'b001;
    localparam [2:0] P_OFF  = 3'b010;
    localparam [2:0] P_WAKE = 3'b100;

    wire [7:0] reg_ptr;
    wire       wr_pulse;
    wire [7:0] wr_addr;
    wire [7:0] wr_data;
    wire       start_pulse;
    reg  [7:0] rd_data;

    reg  [7:0]  cfg [0:NCFG-1];
    reg         power_keep_alive;
    reg  [2:0]  pstate;
    reg  [31:0] grace_cnt;

    function [3:0] slot_of;
        input [7:0] ofs;
        begin
            case (ofs)
                `SSC_OFS_MODE:      slot_of = 4'd0;
                `SSC_OFS_MON_LGAIN: slot_of = 4'd1;
                `SSC_OFS_MON_RGAIN: slot_of = 4'd2;
                `SSC_OFS_PT_CTRL_A: slot_of = 4'd3;
                `SSC_OFS_PT_CTRL_B: slot_of = 4'd4;
                `SSC_OFS_PT_LGAIN:  slot_of = 4'd5;
                `SSC_OFS_PT_RGAIN:  slot_of = 4'd6;
                `SSC_OFS_GL_CTRL:   slot_of = 4'd7;
                `SSC_OFS_GL_TIMING: slot_of = 4'd8;
                `SSC_OFS_GL_HOLD:   slot_of = 4'd9;
                `SSC_OFS_GL_START:  slot_of = 4'd10;
                `SSC_OFS_MT_CTRL:   slot_of = 4'd11;
                `SSC_OFS_NVM_CTRL:  slot_of = 4'd12;
                default:            slot_of = NOSLOT;
            endcase
        end
    endfunction

    // Reserved bits are never stored, so they read back as zero
    function [7:0] mask_of;
        input integer s;
        begin
            case (s)
                4'd1, 4'd2, 4'd4, 4'd5, 4'd6: mask_of = `SSC_MSK_GAIN;
                4'd3:                         mask_of = `SSC_MSK_PT_CTRL_A;
                4'd10:                        mask_of = `SSC_MSK_GL_START;
                4'd11:                        mask_of = `SSC_MSK_MT_CTRL;
                4'd12:                        mask_of = `SSC_MSK_NVM_CTRL;
                default:                      mask_of = `SSC_MSK_FULL;
            endcase
        end
    endfunction

    ssc_i2c_slave #(
        .DEV_ADDR (DEV_ADDR)
    ) u_i2c (
        .mclk        (mclk),
        .nrst        (nrst),
        .scl_in      (scl_in),
        .sda_in      (sda_in),
        .sda_out     (sda_out),
        .sda_oe      (sda_oe),
        .rd_data     (rd_data),
        .reg_ptr     (reg_ptr),
        .wr_pulse    (wr_pulse),
        .wr_addr     (wr_addr),
        .wr_data     (wr_data),
        .start_pulse (start_pulse)
    );

    wire [3:0] wr_slot = slot_of(wr_addr);
    wire [3:0] rd_slot = slot_of(reg_ptr);

    // Bus is never gated by power or mode state
    genvar i;
    generate
        for (i = 0; i < NCFG; i = i + 1) begin : g_cfg
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    cfg[i] <= (i == 0) ? `SSC_RST_MODE : `SSC_RST_CFG;
                end else if (wr_pulse && wr_slot == i) begin
                    cfg[i] <= wr_data & mask_of(i);
                end
            end
        end
    endgenerate

    assign mode_ctrl                  = cfg[0];
    assign monitor_left_mic_gain      = cfg[1];
    assign monitor_right_mic_gain     = cfg[2];
    assign passthrough_mode_ctrl_a    = cfg[3];
    assign passthrough_mode_ctrl_b    = cfg[4];
    assign passthrough_left_mic_gain  = cfg[5];
    assign passthrough_right_mic_gain = cfg[6];
    assign gain_loop_ctrl             = cfg[7];
    assign gain_loop_timing           = cfg[8];
    assign gain_loop_hold_timeout     = cfg[9];
    assign gain_loop_startup          = cfg[10];
    assign mode_transition_ctrl       = cfg[11];
    assign nvm_transfer_ctrl          = cfg[12];
    assign bus_mode                   = cfg[0][`SSC_BIT_BUS_MODE];

    // Command bits also fire a pulse; the test bit asks for the dummy write
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            nvm_cmd_pulse <= 3'b000;
        end else if (wr_pulse && wr_addr == `SSC_OFS_NVM_CTRL) begin
            nvm_cmd_pulse <= wr_data[2:0];
        end else begin
            nvm_cmd_pulse <= 3'b000;
        end
    end

    // Read mux; flags come from same-clock logic and need no synchroniser
    always @* begin
        rd_data = 8'h00;
        if (reg_ptr == `SSC_OFS_IDENT) begin
            rd_data = {REVISION_CODE, PART_CODE};
        end else if (reg_ptr == `SSC_OFS_STATE) begin
            rd_data[`SSC_BIT_TEST_PASS]    = nvm_test_pass_flag;
            rd_data[`SSC_BIT_NVM_IDLE]     = nvm_idle_flag;
            rd_data[`SSC_BIT_STARTUP_DONE] = startup_done_flag;
            rd_data[`SSC_BIT_KEEP_ALIVE]   = power_keep_alive;
        end else if (rd_slot != NOSLOT) begin
            rd_data = cfg[rd_slot];
        end
    end

    // Only bit 0 of the state register takes a write
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            power_keep_alive <= `SSC_RST_KEEP_ALIVE;
        end else if (wr_pulse && wr_addr == `SSC_OFS_STATE) begin
            power_keep_alive <= wr_data[`SSC_BIT_KEEP_ALIVE];
        end
    end

    wire [1:0]  grace_code  = cfg[11][`SSC_GRACE_HI:`SSC_GRACE_LO];
    wire [33:0] grace_wide  = {32'h0, grace_code} + 34'h1;
    wire [63:0] grace_prod  = {32'h0, grace_wide[31:0]} * {32'h0, GRACE_UNIT_CYCLES};
    wire [31:0] grace_limit = grace_prod[31:0];

    // Power sequencing; a start in the same cycle as expiry is not seen, so the device still powers down
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pstate    <= P_ON;
            grace_cnt <= 32'h0;
        end else begin
            case (pstate)
                P_ON: begin
                    if (bus_mode && !power_keep_alive) begin
                        pstate <= P_OFF;
                    end
                end
                P_OFF: begin
                    grace_cnt <= 32'h0;
                    if (!bus_mode) begin
                        pstate <= P_ON;
                    end else if (start_pulse) begin
                        pstate <= P_WAKE;
                    end
                end
                P_WAKE: begin
                    grace_cnt <= grace_cnt + 32'h1;
                    if (!bus_mode || power_keep_alive) begin
                        pstate <= P_ON;
                    end else if (grace_cnt >= grace_limit - 32'h1) begin
                        pstate <= P_OFF;
                    end
                end
                default: begin
                    pstate <= P_ON;
                end
            endcase
        end
    end

    // Register logic keeps running while off so a start can still be seen
    assign device_powered = ~pstate[1];
endmodule

// *** test/ssc_regs_asserts.sv ***
// Concurrent checks on the ports of the status and control register bank
module ssc_regs_asserts (
    // Clock and reset
    input logic       mclk,
    input logic       nrst,
    // Bus pins
    input logic       scl_in,
    input logic       sda_in,
    input logic       sda_out,
    input logic       sda_oe,
    // Power and commands
    input logic       device_powered,
    input logic       bus_mode,
    input logic [2:0] nvm_cmd_pulse,
    // Register contents
    input logic [7:0] mode_ctrl,
    input logic [7:0] monitor_left_mic_gain,
    input logic [7:0] passthrough_mode_ctrl_a,
    input logic [7:0] gain_loop_startup,
    input logic [7:0] mode_transition_ctrl,
    input logic [7:0] nvm_transfer_ctrl
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_pulse_single: assert property (|nvm_cmd_pulse |=> nvm_cmd_pulse == 3'h0)
        else $error("command pulse longer than one cycle");
    a_pulse_value: assert property (|nvm_cmd_pulse |-> nvm_cmd_pulse == nvm_transfer_ctrl[2:0])
        else $error("command pulse differs from written bits");
    a_drop_needs_mode: assert property ($fell(device_powered) |-> $past(bus_mode))
        else $error("power dropped outside bus-control mode");
    a_local_stays_on: assert property (!bus_mode [*3] |-> device_powered)
        else $error("device off while keep-alive is ignored");
    a_wake_on_start: assert property (!device_powered && scl_in && $fell(sda_in)
        |-> ##[1:10] device_powered)
        else $error("start condition did not wake the device");
    a_oe_on_low: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data driver changed while bus clock high");
    a_cfg_on_low: assert property ($changed({mode_ctrl, mode_transition_ctrl}) |-> !scl_in)
        else $error("register changed outside a write slot");
    a_mode_mirror: assert property (bus_mode == mode_ctrl[0])
        else $error("bus-control mode does not follow its register bit");
    a_reserved_zero: assert property ({monitor_left_mic_gain[7], passthrough_mode_ctrl_a & 8'h4c,
        gain_loop_startup[7:3], mode_transition_ctrl[7:6], nvm_transfer_ctrl[7:3]} == 0)
        else $error("reserved register bit set");
    a_sda_low_only: assert property (sda_out == 1'b0)
        else $error("open drain data value not low");

    cover property ($fell(device_powered));
    cover property (!device_powered ##1 device_powered);
    cover property (nvm_cmd_pulse == 3'h7);
endmodule

bind ssc_regs ssc_regs_asserts u_chk (.mclk, .nrst, .scl_in, .sda_in, .sda_out, .sda_oe,
    .device_powered, .bus_mode, .nvm_cmd_pulse, .mode_ctrl, .monitor_left_mic_gain,
    .passthrough_mode_ctrl_a, .gain_loop_startup, .mode_transition_ctrl, .nvm_transfer_ctrl);

// *** test/ssc_host_model.sv ***
// Host controller model that drives the two-wire register bus
module ssc_host_model #(
    parameter int HALF = 50
) (
    // Clock
    input  logic mclk,
    // Bus lines
    input  logic sda_line,
    output logic scl,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Every change lands just after a clock edge
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic start();
        sda_pull = 1'b0;
        hold(HALF / 2);
        scl = 1'b1;
        hold(HALF);
        sda_pull = 1'b1;
        hold(HALF);
        scl = 1'b0;
        hold(HALF / 2);
    endtask

    task automatic stop();
        sda_pull = 1'b1;
        hold(HALF / 2);
        scl = 1'b1;
        hold(HALF);
        sda_pull = 1'b0;
        hold(HALF);
    endtask

    // Sample late in the high phase, the device only moves data on clock falls
    task automatic bit_io(input logic b, output logic r);
        sda_pull = !b;
        hold(HALF / 2);
        scl = 1'b1;
        hold(HALF);
        r = sda_line;
        scl = 1'b0;
        hold(HALF / 2);
    endtask

    task automatic xfer(input logic [7:0] d, input logic ack_in,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ack_in, ack);
    endtask
endmodule

// *** test/test_system_status_and_control_regs.sv ***
// Self-checking bench for the status and control register bank
module test_system_status_and_control_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam [31:0] G = 32'd1000;
    localparam [3:0] REV = 4'h9;  // Arbitrary code
    localparam [3:0] PART = 4'h2; // Arbitrary code
    localparam [103:0] OFS = {8'h34, 8'h1a, 8'h18, 8'h17, 8'h16, 8'h15, 8'h14,
                              8'h13, 8'h12, 8'h11, 8'h10, 8'h0f, 8'h02};
    logic         mclk = 1'b0;
    logic         nrst = 1'b0;
    logic [2:0]   flg = 3'h0;
    logic [31:0]  rnd = 32'h924b13ac;
    logic [7:0]   ex [0:255];
    logic [7:0]   q;
    logic [2:0]   seen = 3'h0;
    logic         kp = 1'b1;
    logic         nak;
    int           fails = 0;
    int           total_checks = 0;
    wire          scl, h_oe, sda_oe, sda_out, pwr, bmode, sda;
    wire  [2:0]   pulse;
    wire  [103:0] cfg;
    assign sda = !(h_oe || sda_oe);

    always #5 mclk = ~mclk;
    always @(posedge mclk) if (|pulse) seen <= pulse;

    // Short bus bit keeps the run small; still well above the pin filter delay
    ssc_host_model #(.HALF(20)) host (.mclk(mclk), .sda_line(sda), .scl(scl), .sda_pull(h_oe));

    ssc_regs #(.REVISION_CODE(REV), .PART_CODE(PART), .GRACE_UNIT_CYCLES(G)) DUT (
        .mclk(mclk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .nvm_idle_flag(flg[1]), .nvm_test_pass_flag(flg[2]),
        .startup_done_flag(flg[0]), .device_powered(pwr), .bus_mode(bmode),
        .nvm_cmd_pulse(pulse), .mode_ctrl(cfg[7:0]), .monitor_left_mic_gain(cfg[15:8]),
        .monitor_right_mic_gain(cfg[23:16]), .passthrough_mode_ctrl_a(cfg[31:24]),
        .passthrough_mode_ctrl_b(cfg[39:32]), .passthrough_left_mic_gain(cfg[47:40]),
        .passthrough_right_mic_gain(cfg[55:48]), .gain_loop_ctrl(cfg[63:56]),
        .gain_loop_timing(cfg[71:64]), .gain_loop_hold_timeout(cfg[79:72]),
        .gain_loop_startup(cfg[87:80]), .mode_transition_ctrl(cfg[95:88]),
        .nvm_transfer_ctrl(cfg[103:96]));

    function automatic [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic [7:0] msk(input [7:0] o);
        case (o)
            8'h02, 8'h15, 8'h16, 8'h17: msk = 8'hff;
            8'h0f, 8'h10, 8'h12, 8'h13, 8'h14: msk = 8'h7f;
            8'h11: msk = 8'hb3;
            8'h18, 8'h34: msk = 8'h07;
            8'h1a: msk = 8'h3f;
            default: msk = 8'h00;
        endcase
    endfunction

    function automatic [7:0] rv(input [7:0] o);
        case (o)
            8'h00: rv = {REV, PART};
            8'h01: rv = {3'h0, flg[2], flg[1], 1'b0, flg[0], kp};
            default: rv = ex[o];
        endcase
    endfunction

    task automatic chk(input [7:0] got, input [7:0] want, input string m);
        total_checks++;
        if (got !== want) begin
            fails++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, got, want);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // A single byte writes v, a burst writes random bytes
    task automatic wr(input [7:0] a, input [7:0] v, input int n);
        logic       k;
        logic [7:0] d;
        logic [7:0] o;
        host.start();
        host.xfer(8'h80, 1'b1, d, k);
        host.xfer(a, 1'b1, d, k);
        for (int i = 0; i < n; i++) begin
            rnd = lfsr(rnd);
            d = (n == 1) ? v : rnd[7:0];
            o = a + 8'(i);
            host.xfer(d, 1'b1, q, k);
            chk({7'h0, k}, 8'h00, "data ack");
            ex[o] = d & msk(o);
            if (o == 8'h01) kp = d[0];
        end
        host.stop();
        for (int j = 0; j < 13; j++) begin
            chk(cfg[8*j+:8], ex[OFS[8*j+:8]], "register port");
        end
    endtask

    task automatic rd(input [7:0] a, input int n);
        logic       k;
        logic [7:0] d;
        host.start();
        host.xfer(8'h80, 1'b1, d, k);
        host.xfer(a, 1'b1, d, k);
        host.start();
        host.xfer(8'h81, 1'b1, d, k);
        for (int i = 0; i < n; i++) begin
            host.xfer(8'hff, i == n - 1, d, k);
            chk(d, rv(a + 8'(i)), "read data");
        end
        host.stop();
    endtask

    task automatic end_of_test();
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 256; i++) ex[i] = 8'h00;
        ex[8'h02] = 8'h4c;
        repeat (10) @(posedge mclk);
        #1 nrst = 1'b1;
        cyc(10);
        repeat (2) begin
            rnd = lfsr(rnd);
            flg = rnd[2:0];
            rd(8'h00, 2);
        end
        wr(8'h00, 8'hff, 1);
        wr(8'h01, 8'hfe, 1);
        chk({7'h0, pwr}, 8'h01, "local mode power");
        rd(8'h00, 2);
        // Burst crosses the unmapped hole at 0x19
        wr(8'h0f, 8'h00, 12);
        rd(8'h0f, 12);
        wr(8'h34, 8'hff, 1);
        chk({5'h0, seen}, 8'h07, "command pulse");
        wr(8'h34, 8'h04, 1);
        chk({5'h0, seen}, 8'h04, "test pulse");
        wr(8'h1a, 8'h30, 1);
        // Keep-alive is still clear, so bus-control mode powers down at once
        wr(8'h02, 8'h4d, 1);
        cyc(5);
        chk({7'h0, pwr}, 8'h00, "power down");
        chk({7'h0, bmode}, 8'h01, "bus mode set");
        wr(8'h01, 8'h01, 1);
        cyc(5 * G);
        chk({7'h0, pwr}, 8'h01, "held on");
        wr(8'h01, 8'h00, 1);
        host.start();
        host.stop();
        cyc(2 * G);
        chk({7'h0, pwr}, 8'h01, "woken");
        cyc(3 * G);
        chk({7'h0, pwr}, 8'h00, "grace expired");
        host.start();
        host.xfer(8'h82, 1'b1, q, nak);
        host.stop();
        chk({7'h0, nak}, 8'h01, "foreign address");
        wr(8'h02, 8'h4c, 1);
        cyc(5);
        chk({7'h0, pwr}, 8'h01, "local mode on");
        chk({7'h0, bmode}, 8'h00, "bus mode clear");
        end_of_test();
    end

    // Full sequence needs roughly 40k cycles
    initial begin
        repeat (90000) @(posedge mclk);
        fails++;
        end_of_test();
    end
endmodule
